// *** core/multi_queue_port_flag_control.sv ***
// Contract
// - last device drives chain output low once default configuration is done
// - writes blocked while selected write queue is full, whatever write enable
// - write storing last free word drives full flag low
// - after write queue select, full flag shows the newly selected queue
// - read freeing space in write-selected queue raises full flag
// - selecting another device on write port floats this full flag
// - word written into empty queue selected on both ports falls through
// - on read queue change one remaining old-queue word is still delivered
// - first word of new read queue appears two read clocks after selection
// - with read enable inactive and no fall-through due, output word held
// - read to empty: valid flag high, last word kept on output
// - fresh word placed on output drives valid flag low
// - write into empty selected read queue: valid low with new word
// - owning device drives read data and valid flag; others float them
`timescale 1ns/1ns
module multi_queue_port_flag_control
  import mq_port_pkg::*;
#(
  parameter int DATA_W = DATA_W_DEF,
  parameter int QUEUE_AW = QUEUE_AW_DEF,
  parameter int DEV_AW = DEV_AW_DEF,
  parameter int DEPTH = DEPTH_DEF,
  parameter int CFG_CYCLES = CFG_CYCLES_DEF,
  parameter logic [DEV_AW-1:0] DEVICE_ID = DEVICE_ID_DEF[DEV_AW-1:0]
) (
  input wire logic clock,
  input wire logic resetn,
  // configuration chain
  input wire logic prog_chain_in,
  output logic prog_chain_out,
  // write port
  input wire logic write_sel_strobe,
  input wire logic [DEV_AW+QUEUE_AW-1:0] write_queue_addr,
  input wire logic write_enable_n,
  input wire logic [DATA_W-1:0] write_data,
  output logic queue_full_flag,
  output logic queue_full_flag_oe,
  // read port
  input wire logic read_sel_strobe,
  input wire logic [DEV_AW+QUEUE_AW-1:0] read_queue_addr,
  input wire logic read_enable_n,
  output logic [DATA_W-1:0] read_data,
  output logic read_data_oe,
  output logic output_valid_flag,
  output logic output_valid_flag_oe
);
  // queue count follows the queue address width
  localparam int NQ = 1 << QUEUE_AW;
  // pointers wrap by overflow, so DEPTH must be a power of two
  localparam int PW = $clog2(DEPTH);
  // one bit more than a pointer tells a full queue from an empty one
  localparam int CW = PW + 1;
  // the configuration counter has to reach CFG_CYCLES itself
  localparam int KW = $clog2(CFG_CYCLES + 1);
  // compare values sized to their counters
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
  localparam logic [KW-1:0] CFG_LAST = KW'(CFG_CYCLES);

  typedef struct packed {
    // configuration progress and chain output
    logic [KW-1:0] cfg_cnt;
    logic chain_out;
    // per-queue pointers and fill counts, shared by both ports
    logic [NQ-1:0][PW-1:0] wptr;
    logic [NQ-1:0][PW-1:0] rptr;
    logic [NQ-1:0][CW-1:0] cnt;
    // write port: selection, ownership, full flag and its enable
    logic [QUEUE_AW-1:0] wsel;
    logic wown;
    logic ff;
    logic ff_oe;
    // read port: current selection and the one it replaced
    logic [QUEUE_AW-1:0] rsel;
    logic rown;
    logic [QUEUE_AW-1:0] rold;
    logic rold_own;
    // fall-through phase, valid flag and output bus enable
    rd_phase_t rphase;
    logic ov;
    logic roe;
  } ctrl_state_t;

  ctrl_state_t s_r;
  ctrl_state_t s_nxt;

  logic chain_in_lvl;
  logic cfg_done;
  logic w_do;
  logic r_do;
  logic [QUEUE_AW-1:0] r_q;
  logic [QUEUE_AW-1:0] w_q;
  logic [QUEUE_AW+PW-1:0] w_addr;
  logic [QUEUE_AW+PW-1:0] r_addr;

  // per-queue status decoded once for both ports
  logic [NQ-1:0] q_full;
  logic [NQ-1:0] q_empty;

  // the chain pin comes from another device, off this clock's timing
  pin_sync u_chain_sync (
    .clock(clock),
    .resetn(resetn),
    .pin_in(prog_chain_in),
    .level_out(chain_in_lvl)
  );

  assign cfg_done = (s_r.cfg_cnt == CFG_LAST);

  // both ports see the same count, so the status of one queue can never
  // disagree between the write side and the read side
  for (genvar g = 0; g < NQ; g++) begin : g_queue_status
    assign q_full[g] = (s_r.cnt[g] == DEPTH_C);
    assign q_empty[g] = (s_r.cnt[g] == '0);
  end

  // next state of both ports; the shared counts are all that ties them
  always_comb begin
    s_nxt = s_r;
    // nothing moves unless a port below asks for it
    w_do = 1'b0;
    r_do = 1'b0;
    r_q = s_r.rsel;
    w_q = s_r.wsel;

    // default configuration runs from reset; no serial clock is needed,
    // so the serial programming clock pin does not exist on this block
    if (!cfg_done) begin
      s_nxt.cfg_cnt = s_r.cfg_cnt + KW'(1);
    end

    // chain completion
    // low only once this device and every device upstream are done, so
    // the last device's output speaks for the whole chain
    if (cfg_done && !chain_in_lvl) begin
      s_nxt.chain_out = 1'b0;
    end else begin
      s_nxt.chain_out = 1'b1;
    end

    // write port side
    // selects before configuration ends are dropped, as are writes
    if (cfg_done && write_sel_strobe) begin
      // upper address bits name the device, lower bits the queue; a select
      // naming another device releases the full flag
      s_nxt.wsel = write_queue_addr[QUEUE_AW-1:0];
      s_nxt.wown = (write_queue_addr[DEV_AW+QUEUE_AW-1:QUEUE_AW] == DEVICE_ID);
    end

    // full blocks write
    // a write in the strobe cycle still goes to the old selection, which
    // lets the writer switch queues without losing a cycle
    if (cfg_done
        && s_r.wown
        && !write_enable_n
        && !q_full[s_r.wsel]) begin
      w_do = 1'b1;
    end

    // read port side
    // after a select the port runs two fixed steps, old word then new
    // word, before it returns to reads on demand
    case (s_r.rphase)
      RD_OLD: begin
        // old word delivered
        // the old queue still owes one word; stale marks wait a step
        r_q = s_r.rold;
        r_do = s_r.rold_own && !q_empty[s_r.rold];
        s_nxt.rphase = RD_NEW;
      end

      RD_NEW: begin
        r_do = s_r.rown && !q_empty[s_r.rsel];
        s_nxt.rphase = RD_RUN;
        // bus ownership moves with the new word
        s_nxt.roe = s_r.rown;
        // an empty new queue leaves the old word on the bus, marked stale
        if (s_r.rown && !r_do) begin
          s_nxt.ov = 1'b1;
        end
      end

      RD_RUN: begin
        // stale output pulls a fresh word
        // a stale output takes the next word whatever the enable, which is
        // what lets a write into an empty queue fall through
        r_do = s_r.rown
            && !q_empty[s_r.rsel]
            && (s_r.ov || !read_enable_n);
        // read to empty
        // a reader asking an empty queue sees the word turn stale
        if (s_r.rown && !r_do && !read_enable_n) begin
          s_nxt.ov = 1'b1;
        end
      end

      default: begin
        // an unknown phase falls back to reads on demand
        s_nxt.rphase = RD_RUN;
      end
    endcase

    // write-driven fall-through
    // a delivery marks the word fresh and wins over the stale marks above,
    // so a write into a stale, empty queue turns the flag fresh
    if (r_do) begin
      s_nxt.ov = 1'b0;
    end

    // a new select restarts the two steps, even in the middle of them
    if (cfg_done && read_sel_strobe) begin
      // the replaced queue becomes the source of the one old word
      s_nxt.rold = s_r.rsel;
      s_nxt.rold_own = s_r.rown;
      s_nxt.rsel = read_queue_addr[QUEUE_AW-1:0];
      s_nxt.rown = (read_queue_addr[DEV_AW+QUEUE_AW-1:QUEUE_AW] == DEVICE_ID);
      s_nxt.rphase = RD_OLD;
    end

    // a write and a read on one queue in one cycle leave its count alone;
    // pointers step inside their own queue's block only
    for (int q = 0; q < NQ; q++) begin
      if (w_do && (w_q == QUEUE_AW'(q))) begin
        s_nxt.wptr[q] = s_r.wptr[q] + PW'(1);
      end
      if (r_do && (r_q == QUEUE_AW'(q))) begin
        s_nxt.rptr[q] = s_r.rptr[q] + PW'(1);
      end
      case ({w_do && (w_q == QUEUE_AW'(q)), r_do && (r_q == QUEUE_AW'(q))})
        2'b10: s_nxt.cnt[q] = s_r.cnt[q] + CW'(1);
        2'b01: s_nxt.cnt[q] = s_r.cnt[q] - CW'(1);
        default: s_nxt.cnt[q] = s_r.cnt[q];
      endcase
    end

    // read frees space
    // flag taken from the next count and selection, so it moves at the
    // edge of the write, read or select behind it; with one clock for
    // both ports the extra clock of a missed skew never arises
    if ((s_nxt.cnt[s_nxt.wsel] == DEPTH_C) && s_nxt.wown) begin
      s_nxt.ff = 1'b0;
    end else begin
      s_nxt.ff = 1'b1;
    end

    // float when deselected
    // a deselected device leaves the not-full level behind its disabled
    // driver, so a bus model without a pull-up still reads sane
    s_nxt.ff_oe = s_nxt.wown;
  end

  // queue number above pointer: each queue owns a fixed block of words
  assign w_addr = {w_q, s_r.wptr[w_q]};
  assign r_addr = {r_q, s_r.rptr[r_q]};

  // read data leave straight from the memory's output register
  queue_ram #(
    .WIDTH(DATA_W),
    .AW(QUEUE_AW + PW)
  ) u_ram (
    .clock(clock),
    .wr_en(w_do),
    .wr_addr(w_addr),
    .wr_data(write_data),
    .rd_en(r_do),
    .rd_addr(r_addr),
    .rd_data(read_data)
  );

  // reset clears every queue; the read data register is left alone, so
  // its word means nothing until the first delivery
  always_ff @(posedge clock) begin
    if (!resetn) begin
      s_r <= '0;
      // idle chain, not full and stale
      s_r.chain_out <= CHAIN_OUT_RESET;
      s_r.ff <= FULL_FLAG_RESET;
      s_r.ov <= VALID_FLAG_RESET;
      s_r.rphase <= RD_RUN;
    end else begin
      s_r <= s_nxt;
    end
  end

  // every output is a state bit; no logic between flop and pin
  assign prog_chain_out = s_r.chain_out;
  assign queue_full_flag = s_r.ff;
  assign queue_full_flag_oe = s_r.ff_oe;
  assign output_valid_flag = s_r.ov;
  assign read_data_oe = s_r.roe;
  assign output_valid_flag_oe = s_r.roe;

endmodule : multi_queue_port_flag_control

// *** core/mq_port_pkg.sv ***
package mq_port_pkg;

  localparam int DATA_W_DEF = 18;
  localparam int QUEUE_AW_DEF = 4;
  localparam int DEV_AW_DEF = 3;
  localparam int DEPTH_DEF = 16;
  localparam int CFG_CYCLES_DEF = 16;
  localparam logic [2:0] DEVICE_ID_DEF = 3'h0;

  localparam logic FULL_FLAG_RESET = 1'b1;
  localparam logic VALID_FLAG_RESET = 1'b1;
  localparam logic CHAIN_OUT_RESET = 1'b1;

  typedef enum logic [2:0] {
    RD_RUN = 3'b001,
    RD_OLD = 3'b010,
    RD_NEW = 3'b100
  } rd_phase_t;

endpackage : mq_port_pkg

// *** core/pin_sync.sv ***
`timescale 1ns/1ns
module pin_sync (
  input wire logic clock,
  input wire logic resetn,
  input wire logic pin_in,
  output logic level_out
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } sync_state_t;

  sync_state_t s_r;
  sync_state_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.s1 = pin_in;
    s_nxt.s2 = s_r.s1;
    s_nxt.s3 = s_r.s2;
    // a change counts only once two stages agree
    if (s_r.s2 == s_r.s3) begin
      s_nxt.lvl = s_r.s3;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      s_r <= '1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign level_out = s_r.lvl;
endmodule : pin_sync

// *** core/queue_ram.sv ***
`timescale 1ns/1ns
module queue_ram #(
  parameter int WIDTH = 18,
  parameter int AW = 8
) (
  input wire logic clock,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [0:(1<<AW)-1];
  logic [WIDTH-1:0] rd_data_r;

  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // read register holds its word until the next delivery
  always_ff @(posedge clock) begin
    if (rd_en) begin
      rd_data_r <= mem[rd_addr];
    end
  end

  assign rd_data = rd_data_r;
endmodule : queue_ram

// *** sim/mq_flag_checker.sv ***
`timescale 1ns/1ns
module mq_flag_checker
  import mq_port_pkg::*;
#(
  parameter int DATA_W = DATA_W_DEF,
  parameter int QUEUE_AW = QUEUE_AW_DEF,
  parameter int DEV_AW = DEV_AW_DEF,
  parameter logic [DEV_AW-1:0] DEVICE_ID = '0
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic prog_chain_in,
  input wire logic prog_chain_out,
  input wire logic write_sel_strobe,
  input wire logic [DEV_AW+QUEUE_AW-1:0] write_queue_addr,
  input wire logic queue_full_flag,
  input wire logic queue_full_flag_oe,
  input wire logic read_sel_strobe,
  input wire logic [DEV_AW+QUEUE_AW-1:0] read_queue_addr,
  input wire logic read_enable_n,
  input wire logic [DATA_W-1:0] read_data,
  input wire logic read_data_oe,
  input wire logic output_valid_flag,
  input wire logic output_valid_flag_oe
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  wire go = !prog_chain_out;
  wire wr_own = write_queue_addr[QUEUE_AW+:DEV_AW] == DEVICE_ID;
  wire rd_own = read_queue_addr[QUEUE_AW+:DEV_AW] == DEVICE_ID;
  sequence wr_sel;
    go && write_sel_strobe ##1 !write_sel_strobe;
  endsequence
  // checked on the third cycle after the strobe, the first to show the new bus enable
  sequence rd_sel;
    go && read_sel_strobe ##1 !read_sel_strobe [*2];
  endsequence
  chain_gate_a: assert property ($fell(prog_chain_out) |-> !$past(prog_chain_in, 2))
    else $error("chain early");
  ff_owner_a: assert property (wr_sel |=> queue_full_flag_oe == $past(wr_own, 2))
    else $error("full owner");
  ff_float_a: assert property (!queue_full_flag_oe |-> queue_full_flag)
    else $error("full idle");
  rd_owner_a: assert property (rd_sel |=> read_data_oe == $past(rd_own, 3))
    else $error("read owner");
  oe_pair_a: assert property (read_data_oe == output_valid_flag_oe)
    else $error("oe pair");
  fresh_word_a: assert property (read_data_oe && $changed(read_data) |-> !output_valid_flag)
    else $error("fresh word");
  word_hold_a: assert property (go && read_enable_n && !output_valid_flag
    && !read_sel_strobe && !$past(read_sel_strobe)
    && !$past(read_sel_strobe, 2) |=> $stable(read_data))
    else $error("word hold");
  empty_keep_a: assert property (read_data_oe && output_valid_flag
    && $past(output_valid_flag) |-> $stable(read_data))
    else $error("empty keep");
endmodule : mq_flag_checker

bind multi_queue_port_flag_control mq_flag_checker #(
  .DATA_W(DATA_W), .QUEUE_AW(QUEUE_AW), .DEV_AW(DEV_AW), .DEVICE_ID(DEVICE_ID)
) mq_flag_checker_inst (.*);

// *** sim/chain_upstream.sv ***
`timescale 1ns/1ns
module chain_upstream (
  input wire logic clock,
  input wire logic resetn,
  output logic done_n = 1'h1
);
  // upstream link reports done after reset; no serial clock exists
  always @(posedge clock) begin
    done_n <= !resetn;
  end
endmodule : chain_upstream

// *** sim/multi_queue_port_flag_control_tb.sv ***
`timescale 1ns/1ns
module multi_queue_port_flag_control_tb;
  import mq_port_pkg::*;
  logic clock = 1'h0, resetn = 1'h0, prog_chain_in, prog_chain_out;
  logic write_sel_strobe = 1'h0, read_sel_strobe = 1'h0;
  logic write_enable_n = 1'h1, read_enable_n = 1'h1;
  logic queue_full_flag, queue_full_flag_oe, read_data_oe;
  logic output_valid_flag, output_valid_flag_oe;
  logic [6:0] write_queue_addr = 7'h00, read_queue_addr = 7'h00;
  logic [17:0] write_data = 18'h00000, read_data;
  logic [17:0] d [20];
  logic [3:0] qa, qb;
  int errors = 0, n_compared = 0;
  initial begin
    forever #50 clock = ~clock;
  end
  chain_upstream chain_upstream_inst (.clock, .resetn, .done_n(prog_chain_in));
  multi_queue_port_flag_control #(.CFG_CYCLES(2)) multi_queue_port_flag_control_inst (.*);
  task automatic chk(input string n, input logic [17:0] e, g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic sel(input logic w, input logic [6:0] a);
    @(posedge clock);
    write_sel_strobe <= w;
    read_sel_strobe <= !w;
    if (w) write_queue_addr <= a;
    else read_queue_addr <= a;
    @(posedge clock);
    write_sel_strobe <= 1'h0;
    read_sel_strobe <= 1'h0;
  endtask : sel
  task automatic put(input int f, n);
    for (int i = f; i < f + n; i++) begin
      @(posedge clock);
      write_enable_n <= 1'h0;
      write_data <= d[i];
    end
    @(posedge clock);
    write_enable_n <= 1'h1;
  endtask : put
  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask : tick
  task automatic finish_test;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  initial begin
    void'($urandom(32'h2129));
    foreach (d[i]) d[i] = 18'($urandom);
    qa = 4'($urandom_range(15));
    qb = qa + 4'($urandom_range(14) + 1);
    repeat (6) @(posedge clock);
    resetn <= 1'h1;
    tick(1);
    chk("valid", 1, output_valid_flag);
    for (int k = 0; k < 60 && prog_chain_out !== 1'h0; k++) tick(1);
    chk("chain", 0, prog_chain_out);
    if (prog_chain_out !== 1'h0) finish_test();
    // port traffic only after the chain reports done
    sel(0, {3'h0, qa});
    sel(1, {3'h0, qb});
    put(18, 2);
    sel(1, {3'h0, qa});
    put(0, 18);
    tick(1);
    chk("full", 0, queue_full_flag);
    chk("fall", d[0], read_data);
    chk("valid", 0, output_valid_flag);
    sel(0, {3'h0, qb});
    tick(2);
    chk("old", d[1], read_data);
    tick(1);
    chk("new", d[18], read_data);
    chk("rd_oe", 1, read_data_oe);
    tick(3);
    chk("hold", d[18], read_data);
    chk("full", 1, queue_full_flag);
    sel(0, {3'h0, qa});
    tick(2);
    chk("old", d[19], read_data);
    tick(1);
    chk("new", d[2], read_data);
    @(posedge clock);
    read_enable_n <= 1'h0;
    tick(1);
    for (int i = 3; i <= 16; i++) begin
      tick(1);
      chk("word", d[i], read_data);
    end
    tick(1);
    chk("empty", 1, output_valid_flag);
    chk("last", d[16], read_data);
    @(posedge clock);
    read_enable_n <= 1'h1;
    sel(1, {3'h1, qa});
    sel(0, {3'h1, qb});
    tick(3);
    chk("ff_oe", 0, queue_full_flag_oe);
    chk("rd_oe", 0, read_data_oe);
    finish_test();
  end
endmodule : multi_queue_port_flag_control_tb
